// *** hw/rac_pkg.sv ***
// rac_pkg: register map, field layout, reset values and timing counts
// for the alarm, square-wave and oscillator control block.
// assumes a 200 MHz system clock and a 16-bit register port.
package rac_pkg;

  // clock rate and timing
  localparam int CLK_MHZ = 200;
  localparam int WARM_TIME_MS = 250;
  localparam int WARM_CYCLES = WARM_TIME_MS * CLK_MHZ * 1000;
  localparam int WARM_CNT_W = 26;

  // register word offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ALARM_LO = 4'h1;
  localparam logic [3:0] OFS_ALARM_HI = 4'h2;
  localparam logic [3:0] OFS_INT_STATUS = 4'h3;
  localparam logic [3:0] OFS_INT_MASK = 4'h4;

  // rtc_control field positions
  localparam int BIT_TOD_EN = 1;
  localparam int BIT_SUB_EN = 2;
  localparam int BIT_TOD_FLAG = 6;
  localparam int BIT_SUB_FLAG = 7;
  localparam int BIT_SQ_EN = 8;
  localparam int BIT_SQ_FREQ = 9;
  localparam int BIT_MODE_LO = 10;
  localparam int BIT_MODE_HI = 11;
  localparam int BIT_OSC_RDY = 13;
  localparam int BIT_OSC_DIS = 14;

  // interrupt status and mask bits
  localparam int INT_TOD = 0;
  localparam int INT_SUB = 1;
  localparam int INT_W = 2;

  // oscillator mode codes
  localparam logic [1:0] MODE_NOISE_IMMUNE = 2'h0;
  localparam logic [1:0] MODE_QUIET = 2'h1;
  localparam logic [1:0] MODE_STOP_WAIT = 2'h2;
  localparam logic [1:0] MODE_STOP_RUN = 2'h3;

  // reset values
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] ALARM_LO_RST = 16'h0000;
  localparam logic [3:0] ALARM_HI_RST = 4'h0;
  localparam logic [1:0] INT_RST = 2'h0;

endpackage : rac_pkg

// *** hw/rac_warmup.sv ***
// rac_warmup: oscillator warm-up timer; start restarts the count,
// abort holds it idle. done_out pulses once when the count runs out.
// assumes start and abort come from logic on the same clock.
`timescale 1ns/1ps
module rac_warmup #(
  parameter int CYCLES = rac_pkg::WARM_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic abort_in,
  output logic busy_out,
  output logic done_out
);
  import rac_pkg::*;

  localparam logic [WARM_CNT_W-1:0] LAST = WARM_CNT_W'(CYCLES - 1);

  logic [WARM_CNT_W-1:0] cnt_q;
  logic [WARM_CNT_W-1:0] cnt_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;
  wire at_end = busy_q && (cnt_q == LAST);

  // next state: abort beats start, start beats expiry
  assign busy_d = abort_in ? 1'b0 : (start_in ? 1'b1 : (busy_q && !at_end));
  assign cnt_d = (abort_in || start_in || !busy_q) ? '0 : cnt_q + 1'b1;
  assign done_d = !abort_in && !start_in && at_end;

  // counter state
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;
endmodule : rac_warmup

// *** hw/rac_ctrl.sv ***
// rac_ctrl: alarm flags, interrupt requests, wake-up, square-wave pin
// and 32k oscillator mode control, behind a plain register port.
// assumes counters, taps, stop and jtag signals share sys_clk_in.
// Functional notes
// - set time-of-day flag when 20-bit seconds count equals alarm value.
// - time-of-day request only when flag, enable and system permit all set.
// - either unmasked alarm counts as a wake-up source.
// - set subsecond flag each time the subsecond timer reloads.
// - subsecond request only when flag, enable and system permit all set.
// - square enable drives the chosen tap on the pin, else pin not driven by it.
// - square-wave output beats jtag tdo on the shared pin.
// - frequency select 1 picks 512 Hz, 0 picks 1 Hz.
// - frequency select has no effect while square output is off.
// - mode change needing warm-up, oscillator enabled, clears ready flag.
// - mode 00 always noise-immune, 01 always quiet.
// - modes 1x go quiet in stop; 10 holds execution during warm-up.
// - input disable turns oscillator off and clears ready flag.
//
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
module rac_ctrl #(
  parameter int WARMUP_CYCLES = rac_pkg::WARM_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  input wire logic [3:0] seconds_count_high_in,
  input wire logic [15:0] seconds_count_low_in,
  input wire logic subsec_reload_in,
  input wire logic sys_int_allow_in,
  input wire logic stop_in,
  input wire logic tap_1hz_in,
  input wire logic tap_512hz_in,
  input wire logic jtag_tdo_in,
  input wire logic jtag_tdo_oe_in,
  output logic port1_bit3_pin_out,
  output logic port1_bit3_pin_oe_out,
  output logic tod_irq_req_out,
  output logic subsec_irq_req_out,
  output logic wake_out,
  output logic irq_out,
  output logic osc_enable_out,
  output logic osc_quiet_out,
  output logic cpu_hold_out
);
  import rac_pkg::*;

  // register state
  logic tod_en_q;
  logic sub_en_q;
  logic tod_flag_q;
  logic sub_flag_q;
  logic sq_en_q;
  logic sq_freq_q;
  logic [1:0] mode_q;
  logic osc_dis_q;
  logic osc_rdy_q;
  logic [15:0] alarm_lo_q;
  logic [3:0] alarm_hi_q;
  logic [INT_W-1:0] int_stat_q;
  logic [INT_W-1:0] int_mask_q;
  logic [15:0] rd_data_q;
  logic match_q;
  logic stop_q;
  logic boot_q;
  logic stop_warm_q;
  logic pin_q;
  logic pin_oe_q;

  // next values
  logic tod_flag_d;
  logic sub_flag_d;
  logic osc_rdy_d;
  logic [INT_W-1:0] int_stat_d;
  logic stop_warm_d;
  logic pin_d;
  logic pin_oe_d;
  logic [15:0] rd_data_d;

  // address decode
  wire sel_ctrl = (addr_in == OFS_CTRL);
  wire sel_alo = (addr_in == OFS_ALARM_LO);
  wire sel_ahi = (addr_in == OFS_ALARM_HI);
  wire sel_stat = (addr_in == OFS_INT_STATUS);
  wire sel_mask = (addr_in == OFS_INT_MASK);
  wire wr_ctrl = wr_in && sel_ctrl;
  wire [1:0] new_mode = wr_data_in[BIT_MODE_HI:BIT_MODE_LO];

  // alarm match; a seconds value stands for many cycles, so only the
  // entry into a match sets the flag, else a cleared flag would re-set
  wire [19:0] secs = {seconds_count_high_in, seconds_count_low_in};
  wire match = (secs == {alarm_hi_q, alarm_lo_q});
  wire tod_set = match && !match_q;
  wire sub_set = subsec_reload_in;

  // flag update: write 0 clears, write 1 keeps, hardware set wins
  wire tod_keep = !(wr_ctrl && !wr_data_in[BIT_TOD_FLAG]);
  wire sub_keep = !(wr_ctrl && !wr_data_in[BIT_SUB_FLAG]);
  assign tod_flag_d = tod_set || (tod_flag_q && tod_keep);
  assign sub_flag_d = sub_set || (sub_flag_q && sub_keep);

  // sticky interrupt status, cleared by writing one; set wins
  wire [INT_W-1:0] ev = {sub_set, tod_set};
  wire [INT_W-1:0] w1c = (wr_in && sel_stat) ? wr_data_in[INT_W-1:0] : '0;
  assign int_stat_d = ev | (int_stat_q & ~w1c);
  assign irq_out = |(int_stat_q & int_mask_q);

  // processor requests and wake-up qualification
  wire tod_live = tod_flag_q && tod_en_q;
  wire sub_live = sub_flag_q && sub_en_q;
  assign tod_irq_req_out = tod_live && sys_int_allow_in;
  assign subsec_irq_req_out = sub_live && sys_int_allow_in;
  assign wake_out = tod_live || sub_live;

  // oscillator mode: quiet in mode 01, or in stop for modes 1x
  function automatic logic quiet_of(input logic [1:0] m, input logic stp);
    quiet_of = (m == MODE_QUIET) || (m[1] && stp);
  endfunction : quiet_of

  assign osc_quiet_out = quiet_of(mode_q, stop_in);
  assign osc_enable_out = !osc_dis_q;

  // warm-up is needed when leaving quiet for noise-immune
  wire mode_warm = wr_ctrl && (new_mode != mode_q) && !osc_dis_q
    && quiet_of(mode_q, stop_in) && !quiet_of(new_mode, stop_in);
  wire stop_exit = stop_q && !stop_in && mode_q[1];
  wire reenable = wr_ctrl && osc_dis_q && !wr_data_in[BIT_OSC_DIS];
  wire warm_start = boot_q || mode_warm || stop_exit || reenable;
  // a re-enable write lands while disable still reads 1; letting the
  // abort win there would lose the restart and strand ready at 0
  wire warm_abort = osc_dis_q && !reenable;
  wire warm_busy;
  wire warm_done;

  rac_warmup #(
    .CYCLES(WARMUP_CYCLES)
  ) u_warm (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .start_in(warm_start),
    .abort_in(warm_abort),
    .busy_out(warm_busy),
    .done_out(warm_done)
  );

  // ready flag: disable and restart clear it, expiry sets it
  assign osc_rdy_d = osc_dis_q ? 1'b0 :
    (warm_start ? 1'b0 : (warm_done ? 1'b1 : osc_rdy_q));

  // execution hold only for mode 10 after a stop exit
  assign stop_warm_d = stop_exit ? 1'b1 : (stop_warm_q && warm_busy);
  assign cpu_hold_out = stop_warm_q && (mode_q == MODE_STOP_WAIT);

  // shared pin: square wave first, jtag tdo otherwise
  wire tap = sq_freq_q ? tap_512hz_in : tap_1hz_in;
  assign pin_d = sq_en_q ? tap : jtag_tdo_in;
  assign pin_oe_d = sq_en_q || jtag_tdo_oe_in;
  assign port1_bit3_pin_out = pin_q;
  assign port1_bit3_pin_oe_out = pin_oe_q;

  // read mux; unmapped offsets read zero
  wire [15:0] ctrl_rd = {1'b0, osc_dis_q, osc_rdy_q, 1'b0, mode_q,
    sq_freq_q, sq_en_q, sub_flag_q, tod_flag_q, 3'h0, sub_en_q,
    tod_en_q, 1'b0};
  assign rd_data_d = !rd_in ? 16'h0000 :
    sel_ctrl ? ctrl_rd :
    sel_alo ? alarm_lo_q :
    sel_ahi ? {12'h000, alarm_hi_q} :
    sel_stat ? {14'h0000, int_stat_q} :
    sel_mask ? {14'h0000, int_mask_q} : 16'h0000;
  assign rd_data_out = rd_data_q;

  // software fields of the control register
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      tod_en_q <= CTRL_RST[BIT_TOD_EN];
      sub_en_q <= CTRL_RST[BIT_SUB_EN];
      sq_en_q <= CTRL_RST[BIT_SQ_EN];
      sq_freq_q <= CTRL_RST[BIT_SQ_FREQ];
      mode_q <= CTRL_RST[BIT_MODE_HI:BIT_MODE_LO];
      osc_dis_q <= CTRL_RST[BIT_OSC_DIS];
    end
    else if (wr_ctrl)
    begin
      tod_en_q <= wr_data_in[BIT_TOD_EN];
      sub_en_q <= wr_data_in[BIT_SUB_EN];
      sq_en_q <= wr_data_in[BIT_SQ_EN];
      sq_freq_q <= wr_data_in[BIT_SQ_FREQ];
      mode_q <= new_mode;
      osc_dis_q <= wr_data_in[BIT_OSC_DIS];
    end
  end

  // alarm value and interrupt mask
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      alarm_lo_q <= ALARM_LO_RST;
      alarm_hi_q <= ALARM_HI_RST;
      int_mask_q <= INT_RST;
    end
    else
    begin
      if (wr_in && sel_alo)
        alarm_lo_q <= wr_data_in;
      if (wr_in && sel_ahi)
        alarm_hi_q <= wr_data_in[3:0];
      if (wr_in && sel_mask)
        int_mask_q <= wr_data_in[INT_W-1:0];
    end
  end

  // hardware-owned state
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      tod_flag_q <= CTRL_RST[BIT_TOD_FLAG];
      sub_flag_q <= CTRL_RST[BIT_SUB_FLAG];
      osc_rdy_q <= CTRL_RST[BIT_OSC_RDY];
      int_stat_q <= INT_RST;
      match_q <= 1'b1;
      stop_q <= 1'b0;
      boot_q <= 1'b1;
      stop_warm_q <= 1'b0;
    end
    else
    begin
      tod_flag_q <= tod_flag_d;
      sub_flag_q <= sub_flag_d;
      osc_rdy_q <= osc_rdy_d;
      int_stat_q <= int_stat_d;
      match_q <= match;
      stop_q <= stop_in;
      boot_q <= 1'b0;
      stop_warm_q <= stop_warm_d;
    end
  end

  // registered pin drive and read data
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      pin_q <= 1'b0;
      pin_oe_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end
    else
    begin
      pin_q <= pin_d;
      pin_oe_q <= pin_oe_d;
      rd_data_q <= rd_data_d;
    end
  end

  // checks on flags, requests, pin and oscillator
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);

  AST_TOD_SET: assert property (
    (match && !match_q) |=> tod_flag_q ##0 int_stat_q[INT_TOD])
    else $error("tod flag not set on alarm match");

  AST_TOD_REQ: assert property (
    tod_irq_req_out |-> (tod_flag_q && tod_en_q && sys_int_allow_in))
    else $error("tod request without flag, enable and permit");

  AST_FLAG_HOLD: assert property (
    (tod_flag_q && !(wr_ctrl && !wr_data_in[BIT_TOD_FLAG])) |=> tod_flag_q)
    else $error("tod flag dropped without a software clear");

  AST_WAKE: assert property (
    (sub_flag_q && sub_en_q) |-> wake_out)
    else $error("unmasked subsecond alarm gives no wake-up");

  AST_SUB_SET: assert property (
    subsec_reload_in |=> sub_flag_q && int_stat_q[INT_SUB])
    else $error("subsecond flag not set on reload");

  AST_SUB_REQ: assert property (
    (sub_flag_q && !sub_en_q) |-> !subsec_irq_req_out)
    else $error("subsecond request while disabled");

  AST_SQ_DRIVE: assert property (
    (sq_en_q && !wr_ctrl) |=> port1_bit3_pin_oe_out ##1 port1_bit3_pin_oe_out)
    else $error("square output enabled but pin not driven");

  AST_SQ_PRIO: assert property (
    (sq_en_q && jtag_tdo_oe_in && !sq_freq_q)
      |=> port1_bit3_pin_out == $past(tap_1hz_in))
    else $error("jtag tdo won over square wave");

  AST_SQ_FREQ: assert property (
    (sq_en_q && sq_freq_q) |=> port1_bit3_pin_out == $past(tap_512hz_in))
    else $error("512 Hz tap not selected");

  AST_FT_IDLE: assert property (
    !sq_en_q |=> port1_bit3_pin_out == $past(jtag_tdo_in)
      && port1_bit3_pin_oe_out == $past(jtag_tdo_oe_in))
    else $error("frequency select affects pin while square output off");

  AST_RDY_MODE: assert property (
    mode_warm |=> !osc_rdy_q)
    else $error("ready flag kept after warm-up mode change");

  AST_MODE_FIXED: assert property (
    (mode_q == MODE_NOISE_IMMUNE) |-> !osc_quiet_out)
    else $error("mode 00 not noise immune");

  AST_STOP_RUN: assert property (
    (mode_q == MODE_STOP_RUN) |-> !cpu_hold_out)
    else $error("mode 11 held execution");

  AST_DIS_RDY: assert property (
    osc_dis_q |=> !osc_rdy_q [*2])
    else $error("ready flag set while input disabled");

  AST_REENABLE: assert property (
    reenable |=> warm_busy && !osc_rdy_q)
    else $error("warm-up not restarted on input re-enable");

  AST_STOP_HOLD: assert property (
    (stop_exit && !wr_ctrl && mode_q == MODE_STOP_WAIT) |=> cpu_hold_out)
    else $error("mode 10 did not hold execution after stop exit");

  AST_SET_WINS: assert property (
    (subsec_reload_in && wr_ctrl && !wr_data_in[BIT_SUB_FLAG]) |=> sub_flag_q)
    else $error("software clear beat hardware set");

  COV_TOD_IRQ: cover property (tod_set ##1 tod_irq_req_out);
  COV_SUB_CLR: cover property (sub_flag_q ##1 !sub_flag_q);
  COV_SQ_512: cover property (sq_en_q && sq_freq_q && jtag_tdo_oe_in);
  COV_WARM: cover property (mode_warm ##[1:1000] warm_done);

endmodule : rac_ctrl

// *** dv/rac_osc_model.sv ***
// rac_osc_model: behavioural 32k divider taps, jtag tdo source and pin wire
// assumes sys_clk_in drives it; tap rates are scaled up to keep runs short
`timescale 1ns/1ps
module rac_osc_model (
  input wire logic sys_clk_in,
  input wire logic osc_enable_in,
  input wire logic pin_in,
  input wire logic pin_oe_in,
  output logic tap_1hz_out,
  output logic tap_512hz_out,
  output logic jtag_tdo_out,
  output logic pin_level_out
);
  logic [4:0] div_q = 5'h00;
  logic last_q = 1'b0;
  // taps stand still while the oscillator is switched off
  always_ff @(posedge sys_clk_in)
  begin
    if (osc_enable_in)
      div_q <= div_q + 5'h01;
    last_q <= pin_level_out;
  end
  assign tap_1hz_out = div_q[4];
  assign tap_512hz_out = div_q[1];
  assign jtag_tdo_out = div_q[0];
  // a released pin flips each cycle so no stale level passes for a drive
  assign pin_level_out = (pin_oe_in === 1'b1) ? pin_in : ~last_q;
endmodule : rac_osc_model

// *** dv/testbench.sv ***
// testbench: self-checking bench for rac_ctrl with the oscillator model
// assumes rac_pkg is compiled first; warm-up shortened to WARM cycles
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module testbench;
  import rac_pkg::*;
  localparam int WARM = 8;
  typedef struct packed {
    logic [15:0] ctrl; logic stop; logic joe; logic eoe; logic [1:0] sel; logic eq;
  } rac_row_t;
  // ctrl, stop, jtag oe, expected oe, pin source (0 tdo 1 slow 2 fast), quiet
  rac_row_t rows [8] = '{
    '{16'h0000, 1'b0, 1'b1, 1'b1, 2'h0, 1'b0}, '{16'h0200, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0},
    '{16'h0100, 1'b1, 1'b0, 1'b1, 2'h1, 1'b0}, '{16'h0300, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0},
    '{16'h0500, 1'b0, 1'b0, 1'b1, 2'h1, 1'b1}, '{16'h0900, 1'b1, 1'b1, 1'b1, 2'h1, 1'b1},
    '{16'h0c00, 1'b0, 1'b0, 1'b0, 2'h0, 1'b0}, '{16'h0e00, 1'b1, 1'b0, 1'b0, 2'h0, 1'b1}};
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sub_rl = 1'b0;
  logic allow = 1'b1, stop = 1'b0, joe = 1'b0;
  logic [3:0] addr = 4'h0, cnt_hi = 4'h0;
  logic [15:0] wdata = 16'h0000, cnt_lo = 16'h0000, rdata, d;
  logic pin, pin_oe, tod_req, sub_req, wake, irq, osc_en, quiet, hold, t1, t512, tdo, lvl;
  logic t1_p = 1'b0, t512_p = 1'b0, tdo_p = 1'b0, exp_pin;
  int errors = 0, total_checks = 0, cycles = 0;
  rac_ctrl #(.WARMUP_CYCLES(WARM)) DUT (.sys_clk_in(sys_clk), .rst_in(rst), .addr_in(addr),
    .wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .seconds_count_high_in(cnt_hi),
    .seconds_count_low_in(cnt_lo), .subsec_reload_in(sub_rl), .sys_int_allow_in(allow),
    .stop_in(stop), .tap_1hz_in(t1), .tap_512hz_in(t512), .jtag_tdo_in(tdo), .jtag_tdo_oe_in(joe),
    .port1_bit3_pin_out(pin), .port1_bit3_pin_oe_out(pin_oe), .tod_irq_req_out(tod_req),
    .subsec_irq_req_out(sub_req), .wake_out(wake), .irq_out(irq), .osc_enable_out(osc_en),
    .osc_quiet_out(quiet), .cpu_hold_out(hold));
  rac_osc_model osc (.sys_clk_in(sys_clk), .osc_enable_in(osc_en), .pin_in(pin),
    .pin_oe_in(pin_oe), .tap_1hz_out(t1), .tap_512hz_out(t512), .jtag_tdo_out(tdo),
    .pin_level_out(lvl));
  // clock and hang guard
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      summarize();
    end
  end
  // pin registers copy the previous cycle's sources
  always @(posedge sys_clk) {t1_p, t512_p, tdo_p} <= {t1, t512, tdo};
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : bus_wr
  // read data stands only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : bus_rd
  initial
  begin
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    #1 `CHK({pin_oe, irq, osc_en, hold}, 4'h2)
    bus_rd(OFS_CTRL, d);
    `CHK(d, CTRL_RST)
    repeat (WARM + 6) @(posedge sys_clk);
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2000)
    bus_rd(4'hf, d);
    `CHK(d, 16'h0000)
    bus_rd(OFS_INT_STATUS, d);
    `CHK(d, {14'h0000, INT_RST})
    // pin source and oscillator mode table
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      stop <= rows[i].stop;
      joe <= rows[i].joe;
      bus_wr(OFS_CTRL, rows[i].ctrl);
      repeat (2) @(posedge sys_clk);
      #1 exp_pin = rows[i].sel == 2'h2 ? t512_p : (rows[i].sel == 2'h1 ? t1_p : tdo_p);
      `CHK(pin_oe, rows[i].eoe)
      `CHK(pin, exp_pin)
      `CHK(quiet, rows[i].eq)
      if (rows[i].eoe)
        `CHK(lvl, exp_pin)
    end
    // time-of-day alarm on a 20-bit match
    @(posedge sys_clk);
    stop <= 1'b0;
    bus_wr(OFS_CTRL, 16'h0006);
    bus_wr(OFS_INT_MASK, 16'h0003);
    bus_wr(OFS_ALARM_LO, 16'h1234);
    bus_wr(OFS_ALARM_HI, 16'h0005);
    repeat (WARM + 6) @(posedge sys_clk);
    cnt_lo <= 16'h1234;
    cnt_hi <= 4'h5;
    repeat (2) @(posedge sys_clk);
    #1 `CHK({tod_req, wake, irq}, 3'h7)
    @(posedge sys_clk);
    allow <= 1'b0;
    #1 `CHK({tod_req, wake}, 2'h1)
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2046)
    bus_wr(OFS_CTRL, 16'h0046);
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2046)
    bus_wr(OFS_CTRL, 16'h0006);
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2006)
    bus_wr(OFS_INT_STATUS, 16'h0001);
    #1 `CHK(irq, 1'b0)
    // subsecond reload beside a clearing write, masked interrupt
    bus_wr(OFS_INT_MASK, 16'h0001);
    allow <= 1'b1;
    @(posedge sys_clk);
    addr <= OFS_CTRL;
    wdata <= 16'h0006;
    wr <= 1'b1;
    sub_rl <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    sub_rl <= 1'b0;
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2086)
    `CHK({sub_req, wake, irq}, 3'h6)
    bus_rd(OFS_INT_STATUS, d);
    `CHK(d, 16'h0002)
    bus_wr(OFS_INT_MASK, 16'h0003);
    #1 `CHK(irq, 1'b1)
    bus_wr(OFS_INT_STATUS, 16'h0002);
    #1 `CHK(irq, 1'b0)
    bus_wr(OFS_CTRL, 16'h0082);
    #1 `CHK({sub_req, wake}, 2'h0)
    // input disable, then mode change needing warm-up
    bus_wr(OFS_CTRL, 16'h4000);
    #1 `CHK(osc_en, 1'b0)
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h4000)
    bus_wr(OFS_CTRL, 16'h0000);
    repeat (WARM + 6) @(posedge sys_clk);
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2000)
    bus_wr(OFS_CTRL, 16'h0400);
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h2400)
    bus_wr(OFS_CTRL, 16'h0000);
    bus_rd(OFS_CTRL, d);
    `CHK(d, 16'h0000)
    // stop exit in the holding mode
    bus_wr(OFS_CTRL, 16'h0800);
    stop <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 `CHK(quiet, 1'b1)
    @(posedge sys_clk);
    stop <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 `CHK({hold, quiet}, 2'h2)
    repeat (WARM + 6) @(posedge sys_clk);
    #1 `CHK(hold, 1'b0)
    summarize();
  end
endmodule : testbench
